// file: shared/strap_defaults_pkg.sv
// Constants for the PHY A and Port 1 strap default loader.
// Contract
// [RQ1] Auto-negotiation enable resets from its strap, one for internal PHY, else zero.
// [RQ2] Auto-negotiation strap shapes speed, duplex, 10BASE-T advertise and mode defaults.
// [RQ3] In fiber mode the auto-negotiation and speed straps leave defaults untouched.
// [RQ4] Speed strap defaults to one; shapes speed, 10BASE-T advertise and mode defaults.
// [RQ5] Speed strap shapes the Port 1 virtual partner ability bits.
// [RQ6] Port 1 falls back to the strapped speed when virtual negotiation fails.
// [RQ7] In RMII MAC mode the polarity strap sets how the speed pin reads.
// [RQ8] Speed and speed polarity straps share one storage bit and one EEPROM bit.
// [RQ9] Duplex strap defaults to one; shapes duplex, 10BASE-T full and mode defaults.
// [RQ10] Straps are captured when power-on or pin reset is released.
// [RQ11] Values loaded from a present EEPROM replace the latched strap values.
// [RQ12] Digital reset or reload without EEPROM reverts to latched values, no resampling.
// [RQ13] Strap values act only as defaults; software writes hold until next reload.
package strap_defaults_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADR_BCTL  = 8'h00;
	localparam logic [7:0] ADR_ADV   = 8'h04;
	localparam logic [7:0] ADR_SMODE = 8'h08;
	localparam logic [7:0] ADR_VPART = 8'h0C;
	localparam logic [7:0] ADR_CTRL  = 8'h10;
	localparam logic [7:0] ADR_STAT  = 8'h14;
	// Field positions inside the registers.
	localparam int BC_AN_BIT   = 12;
	localparam int BC_SPD_BIT  = 13;
	localparam int BC_DPX_BIT  = 8;
	localparam int ADV_FD_BIT  = 6;
	localparam int ADV_HD_BIT  = 5;
	localparam int SM_MODE_LSB = 5;
	localparam int VP_LSB      = 5;
	localparam int CT_DRST_BIT = 0;
	localparam int CT_RLD_BIT  = 1;
	// Bit order of the EEPROM strap word.
	localparam int EE_AN_BIT  = 0;
	localparam int EE_SPD_BIT = 1;
	localparam int EE_DPX_BIT = 2;
	// Tie-off strap values.
	localparam logic SPD_DEF = 1'b1;
	localparam logic DPX_DEF = 1'b1;
	// PHY mode field codes.
	localparam logic [2:0] MODE_ALL = 3'h7;
	localparam logic [2:0] MODE_FX  = 3'h4;
endpackage : strap_defaults_pkg

// file: hdl/phy_port_strap_defaults.sv
// Strap capture and register default loader for PHY A and Port 1.
`timescale 1ns/1ps
module phy_port_strap_defaults (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Strap source and EEPROM loader.
	input  wire logic        port1_internal_phy_select_i,
	input  wire logic        eeprom_present_i,
	input  wire logic        eeprom_load_i,
	input  wire logic [2:0]  eeprom_strap_i,
	// PHY A media.
	input  wire logic        phya_fiber_i,
	// Port 1 speed sources.
	input  wire logic        rmii_mac_mode_i,
	input  wire logic        port1_speed_pin_i,
	input  wire logic        vanego_fail_i,
	input  wire logic        vanego_speed_100_i,
	// PHY A register defaults.
	output logic             phya_autoneg_enable_bit_o,
	output logic             phya_speed_select_lsb_o,
	output logic             phya_duplex_bit_o,
	output logic             phya_adv_10fd_o,
	output logic             phya_adv_10hd_o,
	output logic      [2:0]  phya_mode_o,
	// Port 1 virtual PHY and speed.
	output logic      [3:0]  vphy_partner_ability_o,
	output logic             port1_speed_100_o
);
	import strap_defaults_pkg::*;

	// Strap storage and capture state.
	logic       cap_q, cap_d;
	logic       lat_an_q, lat_an_d;
	logic       an_q, an_d;
	logic       spd_q, spd_d;
	logic       dpx_q, dpx_d;
	logic       apply_q, apply_d;
	// Register fields.
	logic       b_an_q, b_an_d;
	logic       b_spd_q, b_spd_d;
	logic       b_dpx_q, b_dpx_d;
	logic       adv_fd_q, adv_fd_d;
	logic       adv_hd_q, adv_hd_d;
	logic [2:0] mode_q, mode_d;
	logic [3:0] vp_q, vp_d;
	logic       p1_100_q, p1_100_d;
	// Bus state.
	logic        ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	// Decode helpers.
	logic        req, wr, wr_ctrl, revert;
	logic [31:0] mask, cur, nw;

	// Assembles the read word of one register.
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0;
		case (a)
			ADR_BCTL: begin
				w[BC_AN_BIT]  = b_an_q;
				w[BC_SPD_BIT] = b_spd_q;
				w[BC_DPX_BIT] = b_dpx_q;
			end
			ADR_ADV: begin
				w[ADV_FD_BIT] = adv_fd_q;
				w[ADV_HD_BIT] = adv_hd_q;
			end
			ADR_SMODE: w[SM_MODE_LSB +: 3] = mode_q;
			ADR_VPART: w[VP_LSB +: 4] = vp_q;
			ADR_STAT:  w[4:0] = {p1_100_q, lat_an_q, dpx_q, spd_q, an_q};
			default:   w = 32'h0;
		endcase
		return w;
	endfunction : rd_word

	// A request is taken in the cycle before ack; the master holds it until then.
	assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr      = req & wb_we_i;
	assign wr_ctrl = wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0];
	// [RQ12] Revert on reset or reload.
	assign revert  = wr_ctrl & ~eeprom_present_i &
		(wb_dat_i[CT_DRST_BIT] | wb_dat_i[CT_RLD_BIT]);
	assign mask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign nw      = (cur & ~mask) | (wb_dat_i & mask);

	// Read word of the addressed register; a process, so that field changes wake it too.
	always_comb begin
		cur = rd_word(wb_adr_i);
	end

	// Strap capture, EEPROM override and revert; capture has the highest priority.
	always_comb begin
		cap_d    = 1'b0;
		lat_an_d = lat_an_q;
		an_d     = an_q;
		spd_d    = spd_q;
		dpx_d    = dpx_q;
		apply_d  = 1'b0;
		if (cap_q) begin
			// [RQ10] Capture at release.
			lat_an_d = port1_internal_phy_select_i;
			// [RQ1] Autoneg strap from select.
			an_d     = port1_internal_phy_select_i;
			// [RQ4] Speed tie-off default.
			spd_d    = SPD_DEF;
			// [RQ9] Duplex tie-off default.
			dpx_d    = DPX_DEF;
			apply_d  = 1'b1;
		end else if (eeprom_load_i) begin
			// [RQ11] EEPROM replaces straps.
			an_d     = eeprom_strap_i[EE_AN_BIT];
			// [RQ8] Shared speed bit.
			spd_d    = eeprom_strap_i[EE_SPD_BIT];
			dpx_d    = eeprom_strap_i[EE_DPX_BIT];
			apply_d  = 1'b1;
		end else if (revert) begin
			// [RQ12] Latched values, no resampling.
			an_d     = lat_an_q;
			spd_d    = SPD_DEF;
			dpx_d    = DPX_DEF;
			apply_d  = 1'b1;
		end
	end

	// Register fields: defaults load one cycle after the straps change.
	// A default load beats a software write in the same cycle, as a reset would.
	always_comb begin
		b_an_d   = b_an_q;
		b_spd_d  = b_spd_q;
		b_dpx_d  = b_dpx_q;
		adv_fd_d = adv_fd_q;
		adv_hd_d = adv_hd_q;
		mode_d   = mode_q;
		vp_d     = vp_q;
		if (apply_q) begin
			// [RQ3] Fiber ignores autoneg and speed.
			if (phya_fiber_i) begin
				b_an_d   = 1'b0;
				b_spd_d  = 1'b1;
				b_dpx_d  = dpx_q;
				adv_fd_d = 1'b0;
				adv_hd_d = 1'b0;
				mode_d   = MODE_FX;
			end else begin
				// [RQ1] Autoneg enable default.
				b_an_d   = an_q;
				// [RQ2] Autoneg shapes the rest.
				b_spd_d  = an_q | spd_q;
				// [RQ9] Duplex bit default.
				b_dpx_d  = dpx_q & ~an_q;
				// [RQ4] Speed shapes advertise.
				adv_fd_d = dpx_q & (an_q | ~spd_q);
				adv_hd_d = an_q | ~spd_q;
				// [RQ2] Mode field default.
				mode_d   = an_q ? MODE_ALL : {1'b0, spd_q, dpx_q};
			end
			// [RQ5] Partner ability from speed.
			vp_d = {spd_q & dpx_q, spd_q, ~spd_q & dpx_q, ~spd_q};
		end else if (wr) begin
			// [RQ13] Software writes, lost to a default load in the same cycle.
			case (wb_adr_i)
				ADR_BCTL: begin
					b_an_d  = nw[BC_AN_BIT];
					b_spd_d = nw[BC_SPD_BIT];
					b_dpx_d = nw[BC_DPX_BIT];
				end
				ADR_ADV: begin
					adv_fd_d = nw[ADV_FD_BIT];
					adv_hd_d = nw[ADV_HD_BIT];
				end
				ADR_SMODE: mode_d = nw[SM_MODE_LSB +: 3];
				ADR_VPART: vp_d   = nw[VP_LSB +: 4];
				default: begin
				end
			endcase
		end
	end

	// Port 1 speed: the pin in RMII MAC mode, else negotiation with strap fallback.
	always_comb begin
		if (rmii_mac_mode_i) begin
			// [RQ7] Polarity from shared bit.
			p1_100_d = ~(port1_speed_pin_i ^ spd_q);
		end else if (vanego_fail_i) begin
			// [RQ6] Fallback to strap.
			p1_100_d = spd_q;
		end else begin
			p1_100_d = vanego_speed_100_i;
		end
	end

	// Bus answer: every access acks one cycle later; unmapped reads give zero.
	always_comb begin
		ack_d = req;
		dat_d = (req & ~wb_we_i) ? cur : 32'h0;
	end

	// All state registers; the control word is write-only and reads as zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_q    <= 1'b1;
			lat_an_q <= 1'b0;
			an_q     <= 1'b0;
			spd_q    <= SPD_DEF;
			dpx_q    <= DPX_DEF;
			apply_q  <= 1'b0;
			b_an_q   <= 1'b0;
			b_spd_q  <= 1'b0;
			b_dpx_q  <= 1'b0;
			adv_fd_q <= 1'b0;
			adv_hd_q <= 1'b0;
			mode_q   <= 3'h0;
			vp_q     <= 4'h0;
			p1_100_q <= 1'b0;
			ack_q    <= 1'b0;
			dat_q    <= 32'h0;
		end else begin
			cap_q    <= cap_d;
			lat_an_q <= lat_an_d;
			an_q     <= an_d;
			spd_q    <= spd_d;
			dpx_q    <= dpx_d;
			apply_q  <= apply_d;
			b_an_q   <= b_an_d;
			b_spd_q  <= b_spd_d;
			b_dpx_q  <= b_dpx_d;
			adv_fd_q <= adv_fd_d;
			adv_hd_q <= adv_hd_d;
			mode_q   <= mode_d;
			vp_q     <= vp_d;
			p1_100_q <= p1_100_d;
			ack_q    <= ack_d;
			dat_q    <= dat_d;
		end
	end

	// Outputs straight from flip-flops.
	assign wb_dat_o                  = dat_q;
	assign wb_ack_o                  = ack_q;
	assign phya_autoneg_enable_bit_o = b_an_q;
	assign phya_speed_select_lsb_o   = b_spd_q;
	assign phya_duplex_bit_o         = b_dpx_q;
	assign phya_adv_10fd_o           = adv_fd_q;
	assign phya_adv_10hd_o           = adv_hd_q;
	assign phya_mode_o               = mode_q;
	assign vphy_partner_ability_o    = vp_q;
	assign port1_speed_100_o         = p1_100_q;

	// Checks on the design's own outputs and internal state.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// The ack is a single-cycle pulse.
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not given one cycle after request");
	a_capture_autoneg: assert property ( // [RQ1]
		cap_q && !eeprom_load_i |-> ##2 (phya_fiber_i ||
		phya_autoneg_enable_bit_o == $past(port1_internal_phy_select_i, 2)))
		else $error("autoneg default does not follow internal phy select");
	a_fiber_ignores: assert property (apply_q && phya_fiber_i |=> // [RQ3]
		!phya_autoneg_enable_bit_o && phya_speed_select_lsb_o && phya_mode_o == MODE_FX)
		else $error("fiber defaults affected by straps");
	a_partner_speed: assert property (apply_q |=> // [RQ5]
		vphy_partner_ability_o[2] == $past(spd_q) && vphy_partner_ability_o[0] == !$past(spd_q))
		else $error("partner ability not from speed strap");
	a_fallback_speed: assert property (!rmii_mac_mode_i && vanego_fail_i |=> // [RQ6]
		port1_speed_100_o == $past(spd_q))
		else $error("fallback speed not from strap");
	a_pin_polarity: assert property (rmii_mac_mode_i |=> // [RQ7]
		port1_speed_100_o == !($past(port1_speed_pin_i) ^ $past(spd_q)))
		else $error("speed pin polarity wrong");
	a_eeprom_override: assert property (eeprom_load_i && !cap_q |=> // [RQ11]
		spd_q == $past(eeprom_strap_i[EE_SPD_BIT]) && an_q == $past(eeprom_strap_i[EE_AN_BIT]))
		else $error("eeprom values not taken");
	a_revert_latched: assert property (revert && !cap_q && !eeprom_load_i |=> // [RQ12]
		an_q == lat_an_q && spd_q == SPD_DEF && dpx_q == DPX_DEF && apply_q)
		else $error("revert did not restore latched straps");
	a_sw_write_holds: assert property (wr && !apply_q && wb_adr_i == ADR_BCTL && // [RQ13]
		wb_sel_i[1] |=> phya_autoneg_enable_bit_o == $past(wb_dat_i[BC_AN_BIT]))
		else $error("software write lost");
	// Copper duplex and mode defaults follow the straps one cycle after a load.
	a_duplex_default: assert property (apply_q && !phya_fiber_i |=> // [RQ9]
		phya_duplex_bit_o == ($past(dpx_q) && !$past(an_q)))
		else $error("duplex default not from duplex strap");
	a_mode_default: assert property (apply_q && !phya_fiber_i |=> // [RQ2]
		phya_mode_o == ($past(an_q) ? MODE_ALL : {1'b0, $past(spd_q), $past(dpx_q)}))
		else $error("mode default not from straps");

	// Main scenarios.
	c_capture: cover property (cap_q ##2 phya_autoneg_enable_bit_o);
	c_eeprom_load: cover property (eeprom_load_i && !cap_q ##2 apply_q == 1'b0);
	c_revert: cover property (revert ##2 !apply_q);
	c_fallback: cover property (vanego_fail_i && !rmii_mac_mode_i ##1 !port1_speed_100_o);
	c_fiber: cover property (apply_q && phya_fiber_i ##1 phya_mode_o == MODE_FX);
endmodule : phy_port_strap_defaults

// file: bench/phy_port_strap_defaults_test.sv
// Self-checking bench for the PHY A and Port 1 strap default loader.
`timescale 1ns/1ps
module phy_port_strap_defaults_test;
	import strap_defaults_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        sel_i = 1'b1;
	logic        present_i = 1'b0;
	logic        load_i = 1'b0;
	logic [2:0]  strap_i = 3'h0;
	logic        fiber_i = 1'b0;
	logic        rmii_i = 1'b0;
	logic        pin_i = 1'b0;
	logic        fail_i = 1'b0;
	logic        neg100_i = 1'b0;
	logic [7:0]  obs;
	logic [3:0]  vphy;
	logic        spd100;
	logic [31:0] rd;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;

	phy_port_strap_defaults i_phy_port_strap_defaults (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port1_internal_phy_select_i(sel_i),
		.eeprom_present_i(present_i), .eeprom_load_i(load_i), .eeprom_strap_i(strap_i),
		.phya_fiber_i(fiber_i), .rmii_mac_mode_i(rmii_i), .port1_speed_pin_i(pin_i),
		.vanego_fail_i(fail_i), .vanego_speed_100_i(neg100_i),
		.phya_autoneg_enable_bit_o(obs[7]), .phya_speed_select_lsb_o(obs[6]),
		.phya_duplex_bit_o(obs[5]), .phya_adv_10fd_o(obs[4]), .phya_adv_10hd_o(obs[3]),
		.phya_mode_o(obs[2:0]), .vphy_partner_ability_o(vphy), .port1_speed_100_o(spd100));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	// Hang guard: the whole run needs well under a thousand cycles.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end

	// Expected PHY A defaults packed as {an, spd lsb, duplex, 10FD, 10HD, mode}.
	function automatic logic [7:0] dflt(input logic an, input logic spd, input logic dpx,
			input logic fib);
		if (fib) return {1'b0, 1'b1, dpx, 2'b00, MODE_FX};
		return {an, an | spd, dpx & ~an, dpx & (an | ~spd), an | ~spd,
			an ? MODE_ALL : {1'b0, spd, dpx}};
	endfunction : dflt

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One classic Wishbone cycle; the request is held until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		check(32'(wb_ack_o), 32'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// Loader pulse; outputs settle two edges later, two spare edges added.
	task automatic load(input logic [2:0] v);
		@(posedge clk_i);
		load_i  <= 1'b1;
		strap_i <= v;
		@(posedge clk_i);
		load_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : load

	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : do_reset

	task automatic conclude();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Main sequence of tests.
	initial begin
		do_reset();
		check(32'(obs), 32'(dflt(1'b1, 1'b1, 1'b1, 1'b0)));
		check(32'(vphy), 32'hC);
		$display("test done: power-up defaults");
		present_i <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			for (int v = 0; v < 8; v++) begin
				fiber_i <= f[0];
				load(v[2:0]);
				check(32'(obs), 32'(dflt(v[0], v[1], v[2], f[0])));
				check(32'(vphy), 32'({v[1] & v[2], v[1], ~v[1] & v[2], ~v[1]}));
			end
		end
		fiber_i <= 1'b0;
		$display("test done: strap sweep");
		for (int s = 0; s < 2; s++) begin
			load({1'b1, s[0], 1'b0});
			rmii_i <= 1'b1;
			for (int p = 0; p < 2; p++) begin
				pin_i <= p[0];
				repeat (3) @(posedge clk_i);
				check(32'(spd100), {31'h0, ~(p[0] ^ s[0])});
			end
			rmii_i   <= 1'b0;
			fail_i   <= 1'b1;
			neg100_i <= ~s[0];
			repeat (3) @(posedge clk_i);
			check(32'(spd100), 32'(s[0]));
			fail_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			check(32'(spd100), {31'h0, ~s[0]});
		end
		$display("test done: port speed");
		load(3'h7);
		wb(1'b1, ADR_BCTL, 32'h0, rd);
		check(32'(obs[7:5]), 32'h0);
		wb(1'b0, ADR_BCTL, 32'h0, rd);
		check(rd, 32'h0);
		// Pin changes here must not be seen by the revert.
		present_i <= 1'b0;
		sel_i     <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h2, rd);
		repeat (3) @(posedge clk_i);
		check(32'(obs), 32'(dflt(1'b1, 1'b1, 1'b1, 1'b0)));
		wb(1'b0, ADR_STAT, 32'h0, rd);
		check(32'(rd[3:0]), 32'hF);
		// Digital reset with the loader present leaves software values in place.
		wb(1'b1, ADR_BCTL, 32'h0, rd);
		present_i <= 1'b1;
		wb(1'b1, ADR_CTRL, 32'h1, rd);
		repeat (3) @(posedge clk_i);
		check(32'(obs[7:5]), 32'h0);
		present_i <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h1, rd);
		repeat (3) @(posedge clk_i);
		check(32'(obs), 32'(dflt(1'b1, 1'b1, 1'b1, 1'b0)));
		wb(1'b1, 8'h20, 32'hFFFFFFFF, rd);
		wb(1'b0, 8'h20, 32'h0, rd);
		check(rd, 32'h0);
		$display("test done: override and revert");
		do_reset();
		check(32'(obs), 32'(dflt(1'b0, 1'b1, 1'b1, 1'b0)));
		$display("test done: external phy reset");
		conclude();
	end
endmodule : phy_port_strap_defaults_test
